// *** sys_cfg_pkg.sv ***
// constants and carrier types of the system configuration slice
package sys_cfg_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] SEL_4_7_OFFSET = 12'h00C;
	localparam logic [11:0] SEL_8_11_OFFSET = 12'h010;
	localparam logic [11:0] SEL_12_15_OFFSET = 12'h014;
	localparam logic [11:0] BREAK_CTRL_OFFSET = 12'h018;
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
	localparam logic [31:0] BREAK_CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int FIELD_W = 4;
	localparam int LINES_PER_REG = 4;
	localparam int SEL_REGS = 3;
	localparam int LINE_COUNT = 12;
	localparam int SEL_USED_W = 16;
	localparam int CORE_HALT_LINK_BIT = 0;
	localparam int RAM_PARITY_LINK_BIT = 1;
	localparam int RAM_PARITY_FLAG_BIT = 8;

	// ----------------------------------------
	// source codes
	// ----------------------------------------
	localparam logic [3:0] PORT_A = 4'h0;
	localparam logic [3:0] PORT_B = 4'h1;
	localparam logic [3:0] PORT_C = 4'h2;
	localparam logic [3:0] PORT_D = 4'h3;
	localparam logic [3:0] PORT_F = 4'h5;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} apb_rsp_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage : sys_cfg_pkg

// *** ext_line_select_bank.sv ***
// source select fields for external lines 4 to 15
`timescale 1ns/1ps
`default_nettype none
module ext_line_select_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] wr,
	input wire logic [15:0] wdata,
	output logic [47:0] fields,
	output logic [11:0] valid
);

	typedef struct packed {
		logic [47:0] fields;
		logic [11:0] valid;
	} sel_state_t;

	sel_state_t state;
	sel_state_t next_state;
	logic [47:0] next_fields;
	logic [11:0] next_valid;

	// ----------------------------------------
	// per line field update
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < sys_cfg_pkg::LINE_COUNT; i++) begin : g_line
			logic [3:0] f;
			assign f = wr[i / sys_cfg_pkg::LINES_PER_REG]
				? wdata[(i % sys_cfg_pkg::LINES_PER_REG) * 4 +: 4]
				: state.fields[i * 4 +: 4];
			assign next_fields[i * 4 +: 4] = f;
			assign next_valid[i] = (f == sys_cfg_pkg::PORT_A) || (f == sys_cfg_pkg::PORT_B)
				|| (f == sys_cfg_pkg::PORT_C) || (f == sys_cfg_pkg::PORT_D)
				|| (f == sys_cfg_pkg::PORT_F);
		end
	endgenerate

	always_comb begin
		next_state.fields = next_fields;
		next_state.valid = next_valid;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state.fields <= 48'h0000_0000_0000;
			state.valid <= 12'hFFF;
		end else begin
			state <= next_state;
		end
	end

	assign fields = state.fields;
	assign valid = state.valid;

endmodule : ext_line_select_bank
`default_nettype wire

// *** break_link_ctrl.sv ***
// break link enables and ram parity error flag
`timescale 1ns/1ps
`default_nettype none
module break_link_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [31:0] wdata,
	input wire logic parity_error,
	output logic core_halt_link,
	output logic parity_link,
	output logic parity_flag
);

	typedef struct packed {
		logic core_halt_link;
		logic parity_link;
		logic parity_flag;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;

	always_comb begin
		next_state = state;
		// set only, no software clear
		if (wr && wdata[sys_cfg_pkg::CORE_HALT_LINK_BIT]) begin
			next_state.core_halt_link = 1'b1;
		end
		if (wr && wdata[sys_cfg_pkg::RAM_PARITY_LINK_BIT]) begin
			next_state.parity_link = 1'b1;
		end
		// set beats clear
		if (parity_error) begin
			next_state.parity_flag = 1'b1;
		end else if (wr && wdata[sys_cfg_pkg::RAM_PARITY_FLAG_BIT]) begin
			next_state.parity_flag = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ctrl_state_t'(3'h0);
		end else begin
			state <= next_state;
		end
	end

	assign core_halt_link = state.core_halt_link;
	assign parity_link = state.parity_link;
	assign parity_flag = state.parity_flag;

endmodule : break_link_ctrl
`default_nettype wire

// *** sys_cfg_slice.sv ***
// apb register slice: line source selects and timer break links
`timescale 1ns/1ps
`default_nettype none
module sys_cfg_slice (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CORE_HALT_FAULT,
	input wire logic RAM_PARITY_ERROR,
	output logic [47:0] EXT_LINE_SOURCE_FIELD,
	output logic [11:0] EXT_LINE_SOURCE_VALID,
	output logic CORE_HALT_BREAK_LINK,
	output logic RAM_PARITY_BREAK_LINK,
	output logic RAM_PARITY_ERROR_FLAG,
	output logic TIMER_BREAK_INPUTS
);

	typedef struct packed {
		sys_cfg_pkg::bus_state_t bus;
		sys_cfg_pkg::apb_rsp_t rsp;
		logic timer_break;
	} top_state_t;

	top_state_t state;
	top_state_t next_state;
	sys_cfg_pkg::apb_req_t req;
	logic complete;
	logic [2:0] sel_wr;
	logic ctrl_wr;
	logic mapped;
	logic [31:0] read_word;
	logic [47:0] fields;
	logic core_halt_link;
	logic parity_link;
	logic parity_flag;

	// ----------------------------------------
	// bus request and decode
	// ----------------------------------------
	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
	assign complete = req.sel && req.enable && state.rsp.ready;

	always_comb begin
		sel_wr = 3'b000;
		ctrl_wr = 1'b0;
		mapped = 1'b1;
		read_word = 32'h0000_0000;
		case (req.addr)
			sys_cfg_pkg::SEL_4_7_OFFSET: begin
				sel_wr[0] = complete && req.write;
				read_word[15:0] = fields[15:0];
			end
			sys_cfg_pkg::SEL_8_11_OFFSET: begin
				sel_wr[1] = complete && req.write;
				read_word[15:0] = fields[31:16];
			end
			sys_cfg_pkg::SEL_12_15_OFFSET: begin
				sel_wr[2] = complete && req.write;
				read_word[15:0] = fields[47:32];
			end
			sys_cfg_pkg::BREAK_CTRL_OFFSET: begin
				ctrl_wr = complete && req.write;
				read_word[sys_cfg_pkg::CORE_HALT_LINK_BIT] = core_halt_link;
				read_word[sys_cfg_pkg::RAM_PARITY_LINK_BIT] = parity_link;
				read_word[sys_cfg_pkg::RAM_PARITY_FLAG_BIT] = parity_flag;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// register banks
	// ----------------------------------------
	ext_line_select_bank u_select (
		.clk(MCLK),
		.rst(RST),
		.wr(sel_wr),
		.wdata(req.wdata[15:0]),
		.fields(fields),
		.valid(EXT_LINE_SOURCE_VALID)
	);

	break_link_ctrl u_break (
		.clk(MCLK),
		.rst(RST),
		.wr(ctrl_wr),
		.wdata(req.wdata),
		.parity_error(RAM_PARITY_ERROR),
		.core_halt_link(core_halt_link),
		.parity_link(parity_link),
		.parity_flag(parity_flag)
	);

	// ----------------------------------------
	// answer sequencing and break routing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.timer_break = (core_halt_link && CORE_HALT_FAULT)
			|| (parity_link && RAM_PARITY_ERROR);
		case (state.bus)
			sys_cfg_pkg::BUS_IDLE: begin
				if (req.sel && req.enable) begin
					next_state.bus = sys_cfg_pkg::BUS_ANSWER;
					next_state.rsp.ready = 1'b1;
					next_state.rsp.slverr = !mapped;
					next_state.rsp.rdata = req.write ? 32'h0000_0000 : read_word;
				end
			end
			sys_cfg_pkg::BUS_ANSWER: begin
				next_state.bus = sys_cfg_pkg::BUS_IDLE;
				next_state.rsp.ready = 1'b0;
				next_state.rsp.slverr = 1'b0;
			end
			default: begin
				next_state.bus = sys_cfg_pkg::BUS_IDLE;
				next_state.rsp.ready = 1'b0;
				next_state.rsp.slverr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			state.bus <= sys_cfg_pkg::BUS_IDLE;
			state.rsp.ready <= 1'b0;
			state.rsp.slverr <= 1'b0;
			state.rsp.rdata <= 32'h0000_0000;
			state.timer_break <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign PRDATA = state.rsp.rdata;
	assign PREADY = state.rsp.ready;
	assign PSLVERR = state.rsp.slverr;
	assign EXT_LINE_SOURCE_FIELD = fields;
	assign CORE_HALT_BREAK_LINK = core_halt_link;
	assign RAM_PARITY_BREAK_LINK = parity_link;
	assign RAM_PARITY_ERROR_FLAG = parity_flag;
	assign TIMER_BREAK_INPUTS = state.timer_break;

endmodule : sys_cfg_slice
`default_nettype wire

// *** timer_break_model.sv ***
// far side: fault sources and timer break input
`timescale 1ns/1ps
`default_nettype none
module timer_break_model (
	input wire logic clk,
	input wire logic brk,
	output logic halt,
	output logic perr
);
	int breaks = 0;
	initial begin
		halt = 1'h0;
		perr = 1'h0;
	end
	always @(posedge clk) begin
		if (brk === 1'h1) breaks++;
	end
	task automatic drive(input logic h, input logic p);
		@(posedge clk);
		halt <= h;
		perr <= p;
	endtask : drive
endmodule : timer_break_model
`default_nettype wire

// *** sys_cfg_asserts.sv ***
// assertions on the slice ports
`timescale 1ns/1ps
`default_nettype none
module sys_cfg_asserts (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CORE_HALT_FAULT,
	input wire logic RAM_PARITY_ERROR,
	input wire logic CORE_HALT_BREAK_LINK,
	input wire logic RAM_PARITY_BREAK_LINK,
	input wire logic RAM_PARITY_ERROR_FLAG,
	input wire logic TIMER_BREAK_INPUTS
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	wire logic w18 = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h018;
	a_halt_sticky: assert property (CORE_HALT_BREAK_LINK |=> CORE_HALT_BREAK_LINK)
		else $error("halt link dropped");
	a_parity_sticky: assert property (RAM_PARITY_BREAK_LINK |=> RAM_PARITY_BREAK_LINK)
		else $error("parity link dropped");
	a_halt_set: assert property (w18 && PWDATA[0] |=> CORE_HALT_BREAK_LINK)
		else $error("halt link not set");
	a_parity_set: assert property (w18 && PWDATA[1] |=> RAM_PARITY_BREAK_LINK)
		else $error("parity link not set");
	a_flag_hold: assert property (RAM_PARITY_ERROR_FLAG && !(w18 && PWDATA[8]) |=> RAM_PARITY_ERROR_FLAG)
		else $error("flag dropped without clear");
	a_flag_set: assert property (RAM_PARITY_ERROR |=> RAM_PARITY_ERROR_FLAG)
		else $error("flag not set");
	a_flag_cause: assert property ($rose(RAM_PARITY_ERROR_FLAG) |-> $past(RAM_PARITY_ERROR))
		else $error("flag set without error");
	a_flag_clear: assert property (w18 && PWDATA[8] && !RAM_PARITY_ERROR |=> !RAM_PARITY_ERROR_FLAG)
		else $error("flag not cleared");
	a_break_path: assert property (TIMER_BREAK_INPUTS == $past(CORE_HALT_BREAK_LINK
		&& CORE_HALT_FAULT || RAM_PARITY_BREAK_LINK && RAM_PARITY_ERROR))
		else $error("break output wrong");
	a_map_error: assert property (PREADY |-> PSLVERR == !(PADDR inside {12'h00C, 12'h010,
		12'h014, 12'h018}))
		else $error("error response wrong");
	a_reserved_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000)
		else $error("reserved bits not zero");
endmodule : sys_cfg_asserts
bind sys_cfg_slice sys_cfg_asserts u_sys_cfg_asserts (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_HALT_FAULT(CORE_HALT_FAULT),
	.RAM_PARITY_ERROR(RAM_PARITY_ERROR), .CORE_HALT_BREAK_LINK(CORE_HALT_BREAK_LINK),
	.RAM_PARITY_BREAK_LINK(RAM_PARITY_BREAK_LINK),
	.RAM_PARITY_ERROR_FLAG(RAM_PARITY_ERROR_FLAG), .TIMER_BREAK_INPUTS(TIMER_BREAK_INPUTS));
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the slice
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
	} row_t;
	localparam row_t rows [4] = '{'{12'h00C, 32'hFFFF_5321, 32'h0000_5321},
		'{12'h010, 32'h1234_0F04, 32'h0000_0F04}, '{12'h014, 32'hABCD_3210, 32'h0000_3210},
		'{12'h018, 32'hFFFF_FEFD, 32'h0000_0001}};
	logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, halt, perr, hlink, plink, flag, brk, e;
	logic [47:0] fld;
	logic [11:0] vld;
	int miscompares = 0, compares = 0;
	always #50 mclk = ~mclk;
	sys_cfg_slice u_sys_cfg_slice (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CORE_HALT_FAULT(halt), .RAM_PARITY_ERROR(perr),
		.EXT_LINE_SOURCE_FIELD(fld), .EXT_LINE_SOURCE_VALID(vld), .CORE_HALT_BREAK_LINK(hlink),
		.RAM_PARITY_BREAK_LINK(plink), .RAM_PARITY_ERROR_FLAG(flag), .TIMER_BREAK_INPUTS(brk));
	timer_break_model u_timer_break_model (.clk(mclk), .brk(brk), .halt(halt), .perr(perr));
	task automatic chk(input string n, input logic [47:0] s, input logic [47:0] x);
		compares++;
		if (s !== x) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		chk("valid", vld, 12'hFFF);
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, rows[i].a, 32'h0000_0000);
			chk("reset", r, 32'h0000_0000);
		end
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0000_0000);
			chk("readback", r, rows[i].q);
		end
		chk("fields", fld, 48'h3210_0F04_5321);
		chk("valid", vld, 12'hFAF);
		$display("row test done");
		apb(1'h1, 12'h018, 32'h0000_0002);
		apb(1'h1, 12'h018, 32'h0000_0000);
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk("sticky", r, 32'h0000_0003);
		chk("links", {hlink, plink}, 2'h3);
		u_timer_break_model.drive(1'h1, 1'h0);
		repeat (2) @(posedge mclk);
		chk("halt break", brk, 1'h1);
		u_timer_break_model.drive(1'h0, 1'h1);
		repeat (2) @(posedge mclk);
		chk("parity break", brk, 1'h1);
		u_timer_break_model.drive(1'h0, 1'h0);
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk("flag", r, 32'h0000_0103);
		chk("break off", brk, 1'h0);
		apb(1'h1, 12'h018, 32'h0000_0100);
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk("flag clear", r, 32'h0000_0003);
		apb(1'h1, 12'h01C, 32'hFFFF_FFFF);
		chk("unmapped", e, 1'h1);
		apb(1'h0, 12'h01C, 32'h0000_0000);
		chk("unmapped rd", {e, r}, 33'h1_0000_0000);
		$display("break test done");
		rst <= 1'h1;
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		chk("links reset", {hlink, plink, flag}, 3'h0);
		chk("fields reset", fld, 48'h0000_0000_0000);
		chk("valid reset", vld, 12'hFFF);
		u_timer_break_model.drive(1'h0, 1'h1);
		apb(1'h1, 12'h018, 32'h0000_0100);
		u_timer_break_model.drive(1'h0, 1'h0);
		chk("unlinked break", brk, 1'h0);
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk("set wins", r, 32'h0000_0100);
		chk("break cycles", u_timer_break_model.breaks, 32'h0000_0006);
		$display("reset rerun test done");
		summarize();
	end
	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		summarize();
	end
endmodule : tb
`default_nettype wire
